// ===== pkg/kpi_pkg.sv
// Purpose: constants for the pin interrupt unit
// Assumes: one 40 MHz bus clock, 8-bit registers on a plain port
// Notes: register offsets are local word indices
//
// Operation
// [R1] up to eight external pin sources, each with its own enable
// [R2] clock-gate bit set after reset; clearing it stops the unit; code keeps the shallow stop pin wake active while gated
// [R3] keeps running in wait; enabled pin event with enable wakes processor
// [R4] shallow stop: asynchronous pin detection wakes processor without clock
// [R5] deep stop disables the unit and returns all state to reset; code keeps gate bit, pin syncs, status and mask
// [R6] active debug halt: detection and flagging continue as in run
// [R7] per pin: falling or falling+low, or rising or rising+high
// [R8] control bit 3 reads event flag; writes never change it directly
// [R9] writing 1 to bit 2 acknowledges; bit 2 always reads 0
// [R10] bit 1 enables the interrupt request; at 0 no request
// [R11] bit 0 with polarity bits selects edge-only or edge-and-level for all pins
// [R12] each pin enable bit includes its pin when 1, excludes when 0
// [R13] each polarity bit selects active polarity and pull direction
// [R14] polarity 0 selects pullup and falling/low; 1 pulldown and rising/high
// [R15] edges sampled synchronously: deasserted then asserted in next cycle
// [R16] edge-and-level: acknowledge leaves flag set while any enabled pin asserted
// [R17] request output is flag AND enable, held until flag clears
package kpi_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_SC = 4'h0;
  localparam logic [3:0] OFS_PE = 4'h1;
  localparam logic [3:0] OFS_ES = 4'h2;
  localparam logic [3:0] OFS_CG = 4'h3;
  localparam logic [3:0] OFS_ST = 4'h4;
  localparam logic [3:0] OFS_MK = 4'h5;
  localparam int SC_FLAG = 3;
  localparam int SC_ACK = 2;
  localparam int SC_IE = 1;
  localparam int SC_MOD = 0;
  localparam logic [7:0] RST_SC = 8'h00;
  localparam logic [7:0] RST_PE = 8'h00;
  localparam logic [7:0] RST_ES = 8'h00;
  localparam logic RST_CG = 1'b1;
  localparam int EV_FLAG = 0;
  localparam int EV_WAKE = 1;
  localparam int EV_W = 2;
endpackage

// ===== rtl/kpi_keypad_pin_interrupt.sv
// Purpose: eight-pin keypad pin interrupt unit with register port
// Assumes: pins asynchronous to clk; low-power mode inputs from system logic
// Notes: shallow stop wake is combinational from the pins, no clock needed
`timescale 1ns/1ps
module kpi_keypad_pin_interrupt #(
  parameter int PINS = 8
)(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [PINS-1:0] pin_in,
  input wire logic wait_mode,
  input wire logic shallow_stop_mode,
  input wire logic deep_stop_mode,
  input wire logic debug_halt,
  input wire logic [kpi_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic [PINS-1:0] pull_down_sel,
  output logic unit_irq,
  output logic wake_req,
  output logic sys_irq
);
  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  // [R1] eight pins at most
  if (PINS < 1 || PINS > 8)
  begin : g_bad
    $error("PINS must be 1 to 8");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [PINS-1:0] sync1;
  logic [PINS-1:0] sync2;
  logic [PINS-1:0] prev;
  logic [PINS-1:0] pin_en;
  logic [PINS-1:0] pol;
  logic ie;
  logic lvl_mode;
  logic flag;
  logic clk_gate;
  logic [kpi_pkg::EV_W-1:0] ev_stat;
  logic [kpi_pkg::EV_W-1:0] ev_mask;
  logic soft_rst;
  logic run;
  logic [PINS-1:0] asserted;
  logic [PINS-1:0] edge_hit;
  logic any_edge;
  logic any_level;
  logic set_flag;
  logic ack;
  logic async_hit;
  logic [kpi_pkg::EV_W-1:0] ev_in;
  logic wake_s1;
  logic wake_s2;

  // zero-extends a pin vector onto the 8-bit read bus
  function automatic logic [7:0] pad8(input logic [PINS-1:0] v);
    logic [7:0] r;
    r = 8'h00;
    r[PINS-1:0] = v;
    return r;
  endfunction

  // pin at its asserted level and enabled as a source
  function automatic logic [PINS-1:0] pin_active(input logic [PINS-1:0] v,
    input logic [PINS-1:0] p, input logic [PINS-1:0] en);
    return ~(v ^ p) & en;
  endfunction

  // deep stop resets enables, polarity, control, flag and edge history; gate bit and syncs keep
  assign soft_rst = deep_stop_mode;
  // [R2] clock gate
  assign run = clk_gate && !shallow_stop_mode;
  // [R14] polarity 1 means high is asserted
  assign asserted = pin_active(sync2, pol, pin_en);
  // [R15] deasserted sample then asserted sample
  assign edge_hit = asserted & ~pin_active(prev, pol, pin_en);
  assign any_edge = |edge_hit;
  // [R11] level term only in edge-and-level mode
  assign any_level = lvl_mode && (|asserted);
  // [R6] debug halt is not a term: detection carries on
  assign set_flag = run && (any_edge || any_level);
  assign ack = wr && addr == kpi_pkg::OFS_SC && wdata[kpi_pkg::SC_ACK];
  // [R4] asynchronous detection of asserted level while clock stopped
  assign async_hit = |pin_active(pin_in, pol, pin_en);

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else if (run)
    begin
      sync1 <= pin_in;
      sync2 <= sync1;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      prev <= '0;
    else if (soft_rst)
      prev <= '0;
    else if (run)
      prev <= sync2;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_en <= kpi_pkg::RST_PE[PINS-1:0];
      pol <= kpi_pkg::RST_ES[PINS-1:0];
      ie <= kpi_pkg::RST_SC[kpi_pkg::SC_IE];
      lvl_mode <= kpi_pkg::RST_SC[kpi_pkg::SC_MOD];
    end
    // [R5] deep stop reset
    else if (soft_rst)
    begin
      pin_en <= kpi_pkg::RST_PE[PINS-1:0];
      pol <= kpi_pkg::RST_ES[PINS-1:0];
      ie <= kpi_pkg::RST_SC[kpi_pkg::SC_IE];
      lvl_mode <= kpi_pkg::RST_SC[kpi_pkg::SC_MOD];
    end
    else if (wr && clk_gate)
    begin
      if (addr == kpi_pkg::OFS_SC)
      begin
        ie <= wdata[kpi_pkg::SC_IE];
        lvl_mode <= wdata[kpi_pkg::SC_MOD];
      end
      // [R12] pin enables
      else if (addr == kpi_pkg::OFS_PE)
        pin_en <= wdata[PINS-1:0];
      // [R13] polarity and pull select
      else if (addr == kpi_pkg::OFS_ES)
        pol <= wdata[PINS-1:0];
    end
  end

  // the gate bit lives outside the gated domain, so deep stop leaves it alone
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      clk_gate <= kpi_pkg::RST_CG;
    else if (wr && addr == kpi_pkg::OFS_CG)
      clk_gate <= wdata[0];
  end

  // ----------------------------------------------------------------
  // event flag
  // ----------------------------------------------------------------
  // [R8] set by detection only; [R16] set wins over acknowledge
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      flag <= 1'b0;
    else if (soft_rst)
      flag <= 1'b0;
    else if (set_flag)
      flag <= 1'b1;
    // [R9] acknowledge clears
    else if (ack && clk_gate)
      flag <= 1'b0;
  end

  // [R17] [R10] request is flag and enable
  assign unit_irq = flag && ie;
  // [R3] wake from wait on request; [R4] async wake in shallow stop
  assign wake_req = (wait_mode && unit_irq)
    || (shallow_stop_mode && ie && async_hit);
  // [R7] pull direction follows polarity
  assign pull_down_sel = pol;

  // ----------------------------------------------------------------
  // wake event capture
  // ----------------------------------------------------------------
  // the wake term reads raw pins; two flops keep it from
  // reaching the status register asynchronously
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wake_s1 <= 1'b0;
      wake_s2 <= 1'b0;
    end
    else
    begin
      wake_s1 <= wake_req;
      wake_s2 <= wake_s1;
    end
  end

  // ----------------------------------------------------------------
  // system interrupt status
  // ----------------------------------------------------------------
  assign ev_in = {wake_s2, set_flag};

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ev_stat <= '0;
      ev_mask <= '0;
    end
    else
    begin
      if (wr && addr == kpi_pkg::OFS_ST)
        ev_stat <= (ev_stat & ~wdata[kpi_pkg::EV_W-1:0]) | ev_in;
      else
        ev_stat <= ev_stat | ev_in;
      if (wr && addr == kpi_pkg::OFS_MK)
        ev_mask <= wdata[kpi_pkg::EV_W-1:0];
    end
  end

  assign sys_irq = |(ev_stat & ev_mask);

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata <= 8'h00;
    else if (rd)
    begin
      if (addr == kpi_pkg::OFS_SC)
        rdata <= {4'h0, flag, 1'b0, ie, lvl_mode};
      else if (addr == kpi_pkg::OFS_PE)
        rdata <= pad8(pin_en);
      else if (addr == kpi_pkg::OFS_ES)
        rdata <= pad8(pol);
      else if (addr == kpi_pkg::OFS_CG)
        rdata <= {7'h00, clk_gate};
      else if (addr == kpi_pkg::OFS_ST)
        rdata <= {6'h00, ev_stat};
      else if (addr == kpi_pkg::OFS_MK)
        rdata <= {6'h00, ev_mask};
      else
        rdata <= 8'h00;
    end
    else
      rdata <= 8'h00;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  irq_follows_flag_a: assert property (@(posedge clk) disable iff (!arst_n) // [R17]
    unit_irq == (flag && ie)) else $error("request not flag and enable");
  irq_off_a: assert property (@(posedge clk) disable iff (!arst_n) // [R10]
    !ie |-> !unit_irq) else $error("request with enable off");
  flag_set_a: assert property (@(posedge clk) disable iff (!arst_n) // [R15]
    set_flag && !soft_rst |=> flag) else $error("edge did not set flag");
  ack_read_a: assert property (@(posedge clk) disable iff (!arst_n) // [R9]
    rd && addr == kpi_pkg::OFS_SC |=> !rdata[kpi_pkg::SC_ACK]) else $error("ack bit read as one");
  level_hold_a: assert property (@(posedge clk) disable iff (!arst_n) // [R16]
    lvl_mode && run && (|asserted) && !soft_rst |=> flag) else $error("level flag lost");
  deep_reset_a: assert property (@(posedge clk) disable iff (!arst_n) // [R5]
    soft_rst |=> !flag && pin_en == '0 && !ie) else $error("deep stop not reset");
  gate_stop_a: assert property (@(posedge clk) disable iff (!arst_n) // [R2]
    !clk_gate && !flag |=> !flag) else $error("flag set while gated");
  flag_read_a: assert property (@(posedge clk) disable iff (!arst_n) // [R8]
    rd && addr == kpi_pkg::OFS_SC |=> rdata[kpi_pkg::SC_FLAG] == $past(flag))
    else $error("flag read mismatch");
  no_pin_a: assert property (@(posedge clk) disable iff (!arst_n) // [R12]
    pin_en == '0 && !lvl_mode |-> !set_flag) else $error("disabled pin set flag");

  // ----------------------------------------------------------------
  // checks: detection
  // ----------------------------------------------------------------
  debug_run_a: assert property (@(posedge clk) disable iff (!arst_n) // [R6]
    debug_halt && set_flag && !soft_rst |=> flag)
    else $error("flag lost in debug halt");
  edge_set_a: assert property (@(posedge clk) disable iff (!arst_n) // [R7]
    any_edge && run && !soft_rst |=> flag)
    else $error("pin edge did not set flag");
  edge_only_a: assert property (@(posedge clk) disable iff (!arst_n) // [R11]
    !lvl_mode && !any_edge |-> !set_flag)
    else $error("level set flag in edge mode");
  lvl_ack_a: assert property (@(posedge clk) disable iff (!arst_n) // [R16]
    ack && lvl_mode && run && (|asserted) |=> flag)
    else $error("ack cleared flag with pin asserted");
  ack_clear_a: assert property (@(posedge clk) disable iff (!arst_n) // [R9]
    ack && clk_gate && !set_flag && !soft_rst |=> !flag)
    else $error("ack did not clear flag");
  write_no_set_a: assert property (@(posedge clk) disable iff (!arst_n) // [R8]
    wr && addr == kpi_pkg::OFS_SC && wdata[kpi_pkg::SC_FLAG] && !flag && !set_flag |=> !flag)
    else $error("write set the flag");

  // ----------------------------------------------------------------
  // checks: registers
  // ----------------------------------------------------------------
  gate_hold_a: assert property (@(posedge clk) disable iff (!arst_n) // [R2]
    !clk_gate && wr && addr == kpi_pkg::OFS_PE && !soft_rst |=> pin_en == $past(pin_en))
    else $error("write landed while gated");
  cg_keep_a: assert property (@(posedge clk) disable iff (!arst_n) // [R2]
    soft_rst && !(wr && addr == kpi_pkg::OFS_CG) |=> clk_gate == $past(clk_gate))
    else $error("gate bit changed in deep stop");
  pe_read_a: assert property (@(posedge clk) disable iff (!arst_n) // [R12]
    rd && addr == kpi_pkg::OFS_PE |=> rdata == pad8($past(pin_en)))
    else $error("pin enable read mismatch");
  pull_sel_a: assert property (@(posedge clk) disable iff (!arst_n) // [R13]
    pull_down_sel == pol)
    else $error("pull select not polarity");
  es_read_a: assert property (@(posedge clk) disable iff (!arst_n) // [R14]
    rd && addr == kpi_pkg::OFS_ES |=> rdata == pad8($past(pol)))
    else $error("polarity read mismatch");
  idle_read_a: assert property (@(posedge clk) disable iff (!arst_n) // [R8]
    !rd |=> rdata == 8'h00)
    else $error("read data without read");
  irq_hold_a: assert property (@(posedge clk) disable iff (!arst_n) // [R17]
    unit_irq && !soft_rst && !(wr && addr == kpi_pkg::OFS_SC) |=> unit_irq)
    else $error("request dropped early");

  // ----------------------------------------------------------------
  // checks: power modes
  // ----------------------------------------------------------------
  wait_wake_a: assert property (@(posedge clk) disable iff (!arst_n) // [R3]
    wait_mode && unit_irq |-> wake_req)
    else $error("no wake from wait");
  stop_wake_a: assert property (@(posedge clk) disable iff (!arst_n) // [R4]
    shallow_stop_mode && ie && async_hit |-> wake_req)
    else $error("no wake from shallow stop");
  stop_freeze_a: assert property (@(posedge clk) disable iff (!arst_n) // [R4]
    shallow_stop_mode && !soft_rst && !ack |=> flag == $past(flag))
    else $error("flag moved in shallow stop");
  deep_ctrl_a: assert property (@(posedge clk) disable iff (!arst_n) // [R5]
    soft_rst |=> pol == '0 && !lvl_mode)
    else $error("deep stop left control set");
  wake_off_a: assert property (@(posedge clk) disable iff (!arst_n) // [R10]
    !ie |-> !wake_req)
    else $error("wake with enable off");
endmodule

// ===== tb/kpi_pin_model.sv
// Purpose: switch model on the pin side of the pin interrupt unit
// Assumes: each switch shorts its pin to the level opposite the pull
// Notes: a released pin rests at the level its pull resistor gives
`timescale 1ns/1ps
module kpi_pin_model #(
  parameter int PINS = 8
)(
  input wire logic [PINS-1:0] press,
  input wire logic [PINS-1:0] pull_down_sel,
  output logic [PINS-1:0] pin_in
);
  assign pin_in = ~(press ^ pull_down_sel);
endmodule

// ===== tb/keypad_pin_interrupt_tb.sv
// Purpose: register-level bench for the pin interrupt unit
// Assumes: pins driven through the switch model
// Notes: a fixed six-cycle wait covers the pin synchroniser delay
`timescale 1ns/1ps
module keypad_pin_interrupt_tb;
  logic clk = 0, arst_n = 0, wait_mode = 0, shallow_stop_mode = 0;
  logic deep_stop_mode = 0, debug_halt = 0, wr = 0, rd = 0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, press = 8'h00, rdata, pull_down_sel, pin_in;
  logic unit_irq, wake_req, sys_irq;
  int err_count = 0, n_compared = 0;
  kpi_keypad_pin_interrupt u_dut (.clk(clk), .arst_n(arst_n), .pin_in(pin_in),
    .wait_mode(wait_mode), .shallow_stop_mode(shallow_stop_mode),
    .deep_stop_mode(deep_stop_mode), .debug_halt(debug_halt), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pull_down_sel(pull_down_sel),
    .unit_irq(unit_irq), .wake_req(wake_req), .sys_irq(sys_irq));
  kpi_pin_model u_pins (.press(press), .pull_down_sel(pull_down_sel), .pin_in(pin_in));
  initial forever #12.5 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic hold;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // watchdog: whole run is about 130 cycles
  // ----------------------------------------
  initial
  begin
    repeat (3000) @(posedge clk);
    err_count++;
    test_done;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    rchk(kpi_pkg::OFS_SC, kpi_pkg::RST_SC);
    rchk(kpi_pkg::OFS_PE, kpi_pkg::RST_PE);
    rchk(kpi_pkg::OFS_ES, kpi_pkg::RST_ES);
    rchk(kpi_pkg::OFS_CG, {7'h00, kpi_pkg::RST_CG});
    rchk(4'hf, 8'h00);
    wreg(kpi_pkg::OFS_CG, 8'h00);
    wreg(kpi_pkg::OFS_PE, 8'hff);
    rchk(kpi_pkg::OFS_PE, 8'h00);
    wreg(kpi_pkg::OFS_CG, 8'h01);
    $display("test reset and gate done");
    wreg(kpi_pkg::OFS_ES, 8'h0f);
    #1 chk(pull_down_sel, 8'h0f);
    wreg(kpi_pkg::OFS_PE, 8'h03);
    rchk(kpi_pkg::OFS_PE, 8'h03);
    wreg(kpi_pkg::OFS_MK, 8'h01);
    wreg(kpi_pkg::OFS_SC, 8'h06);
    debug_halt <= 1'b1;
    press <= 8'h20;
    hold;
    rchk(kpi_pkg::OFS_SC, 8'h02);
    press <= 8'h21;
    hold;
    rchk(kpi_pkg::OFS_SC, 8'h0a);
    chk({7'h00, unit_irq}, 8'h01);
    chk({7'h00, sys_irq}, 8'h01);
    wait_mode <= 1'b1;
    #1 chk({7'h00, wake_req}, 8'h01);
    wait_mode <= 1'b0;
    wreg(kpi_pkg::OFS_ST, 8'h01);
    #1 chk({7'h00, sys_irq}, 8'h00);
    wreg(kpi_pkg::OFS_SC, 8'h0e);
    rchk(kpi_pkg::OFS_SC, 8'h02);
    wreg(kpi_pkg::OFS_SC, 8'h08);
    rchk(kpi_pkg::OFS_SC, 8'h00);
    press <= 8'h00;
    hold;
    press <= 8'h01;
    hold;
    rchk(kpi_pkg::OFS_SC, 8'h08);
    chk({7'h00, unit_irq}, 8'h00);
    $display("test edge mode done");
    wreg(kpi_pkg::OFS_SC, 8'h07);
    hold;
    rchk(kpi_pkg::OFS_SC, 8'h0b);
    press <= 8'h00;
    hold;
    wreg(kpi_pkg::OFS_SC, 8'h07);
    rchk(kpi_pkg::OFS_SC, 8'h03);
    wreg(kpi_pkg::OFS_ES, 8'h0d);
    hold;
    // a flipped pull looks asserted until the synchroniser catches up
    wreg(kpi_pkg::OFS_SC, 8'h07);
    rchk(kpi_pkg::OFS_SC, 8'h03);
    press <= 8'h02;
    hold;
    rchk(kpi_pkg::OFS_SC, 8'h0b);
    press <= 8'h00;
    hold;
    wreg(kpi_pkg::OFS_SC, 8'h07);
    rchk(kpi_pkg::OFS_SC, 8'h03);
    $display("test level mode done");
    shallow_stop_mode <= 1'b1;
    press <= 8'h01;
    #1 chk({7'h00, wake_req}, 8'h01);
    @(posedge clk);
    shallow_stop_mode <= 1'b0;
    press <= 8'h00;
    deep_stop_mode <= 1'b1;
    repeat (2) @(posedge clk);
    deep_stop_mode <= 1'b0;
    rchk(kpi_pkg::OFS_PE, 8'h00);
    rchk(kpi_pkg::OFS_SC, 8'h00);
    $display("test low power done");
    test_done;
  end
endmodule
